// ### hdl/bit_ops_branch_exec.v
// execution unit for bit-oriented file ops and relative branches
`timescale 1ns/1ps
`default_nettype none
`include "bit_ops_defines.vh"
//////////////////////////////////////////////////////////////////////////////
// How it works
// - PC change or true test costs two cycles, second one a no-op.
// - indirect access with pointer MSb set adds one more cycle.
// - bit clear writes zero to chosen bit, flags untouched.
// - bit set writes one to chosen bit, others and flags kept, one cycle.
// - skip-if-clear discards next instruction when tested bit is zero.
// - skip-if-set discards next instruction when tested bit is one.
// - relative branch loads PC+1 plus signed 9-bit literal, two cycles.
// - register branch adds unsigned W to PC+1, two cycles.
module bit_ops_branch_exec
#(
  parameter PC_W   = 15,
  parameter BANK_W = 6
)
(
  input  wire              clk,
  input  wire              sys_rst,
  input  wire              instr_valid,
  input  wire [13:0]       instr,
  input  wire [BANK_W-1:0] bank_sel,
  input  wire [7:0]        wreg,
  input  wire [15:0]       ptr0,
  input  wire [15:0]       ptr1,
  input  wire [7:0]        file_rd_data,
  output reg               busy_ff,
  output reg  [PC_W-1:0]   pc_ff,
  output reg  [BANK_W+6:0] data_addr_ff,
  output reg               file_wr_en_ff,
  output reg  [7:0]        file_wr_data_ff,
  output reg               ind_addr_ff,
  output reg  [15:0]       ind_ptr_ff,
  output reg               flush_ff,
  output reg               nop_cycle_ff
);
  //////////////////////////////////////////////////////////////////////////////
  // decode
  localparam S_IDLE = 3'b001;
  localparam S_IND  = 3'b010;
  localparam S_NOP  = 3'b100;

  reg  [2:0]        state_ff;
  reg  [2:0]        nxt_state;
  reg  [13:0]       hold_ff;

  wire [13:0]       cur;
  wire              is_bitop;
  wire [1:0]        bop;
  wire [2:0]        bsel;
  wire [6:0]        fop;
  wire              is_bra;
  wire              is_brw;
  wire              hits_ind;
  wire [15:0]       ptr_sel;
  wire              need_ind;
  wire [BANK_W+6:0] full_addr;
  wire              take;
  wire              wr_op;

  // the stalled instruction is replayed from hold_ff in the extra cycle
  assign cur       = (state_ff == S_IND) ? hold_ff : instr;
  assign is_bitop  = (cur[13:12] == `OPC_GRP_BITS);
  assign bop       = cur[11:10];
  assign bsel      = cur[9:7];
  assign fop       = cur[6:0];
  assign is_bra    = (cur[13:9] == `OPC_BRA_TOP);
  assign is_brw    = (cur == `OPC_BRW);
  assign hits_ind  = is_bitop && ((fop == `INDF0_ADDR) || (fop == `INDF1_ADDR));
  assign ptr_sel   = fop[0] ? ptr1 : ptr0;
  assign need_ind  = hits_ind && ptr_sel[15];
  // bank joined with operand; indirect path is resolved by the pointer user
  assign full_addr = {bank_sel, fop};
  assign take      = (state_ff == S_IDLE) && instr_valid;
  assign wr_op     = is_bitop && ((bop == `BITOP_CLR) || (bop == `BITOP_SET));

  //////////////////////////////////////////////////////////////////////////////
  // bit manipulation

  wire [7:0]        rmw_data;
  wire              tbit;

  file_rmw_unit u_rmw
  (
    .rd_data (file_rd_data),
    .bit_sel (bsel),
    .set_val (bop == `BITOP_SET),
    .wr_data (rmw_data),
    .bit_val (tbit)
  );

  //////////////////////////////////////////////////////////////////////////////
  // branch targets and skip conditions

  wire [PC_W-1:0]   pc_inc;
  wire [PC_W-1:0]   k_ext;
  wire [PC_W-1:0]   w_ext;
  wire              skip_c;
  wire              skip_s;
  wire              skip;

  assign pc_inc = pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
  // literal is sign-extended, working register zero-extended
  assign k_ext  = {{(PC_W-9){cur[8]}}, cur[8:0]};
  assign w_ext  = {{(PC_W-8){1'b0}}, wreg};
  assign skip_c = (bop == `BITOP_TSC) && !tbit;
  assign skip_s = (bop == `BITOP_TSS) && tbit;
  assign skip   = is_bitop && (skip_c || skip_s);

  //////////////////////////////////////////////////////////////////////////////
  // sequencing
  // idle executes at once; an indirect access through a high pointer waits
  // one cycle in S_IND; a skip or a branch spends the next cycle in S_NOP

  reg               go;
  reg  [PC_W-1:0]   nxt_pc;

  always @*
  begin
    nxt_state = state_ff;
    nxt_pc    = pc_ff;
    go        = 1'b0;
    case (state_ff)
      S_IDLE:
      begin
        if (instr_valid && need_ind)
          nxt_state = S_IND;
        else if (instr_valid)
          go = 1'b1;
      end
      S_IND:
        go = 1'b1;
      S_NOP:
        nxt_state = S_IDLE;
      default:
        nxt_state = S_IDLE;
    endcase
    if (go)
    begin
      nxt_pc = pc_inc;
      if (is_bra)
        nxt_pc = pc_inc + k_ext;
      else if (is_brw)
        nxt_pc = pc_inc + w_ext;
      if (is_bra || is_brw || skip)
        nxt_state = S_NOP;
      else
        nxt_state = S_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state and program counter

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_ff <= S_IDLE;
      pc_ff    <= `PC_RST;
      hold_ff  <= 14'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      pc_ff    <= nxt_pc;
      if (take)
        hold_ff <= instr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pipeline control pulses

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      busy_ff      <= 1'b0;
      flush_ff     <= 1'b0;
      nop_cycle_ff <= 1'b0;
    end
    else
    begin
      // busy tells the fetch side to hold the next instruction back
      busy_ff      <= (nxt_state != S_IDLE);
      flush_ff     <= go && (nxt_state == S_NOP);
      nop_cycle_ff <= (state_ff == S_NOP);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data address of the last bit op

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      data_addr_ff <= {(BANK_W+7){1'b0}};
      ind_addr_ff  <= 1'b0;
      ind_ptr_ff   <= 16'h0000;
    end
    else if (go && is_bitop)
    begin
      data_addr_ff <= full_addr;
      ind_addr_ff  <= hits_ind;
      ind_ptr_ff   <= ptr_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // file write-back

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      file_wr_en_ff   <= 1'b0;
      file_wr_data_ff <= 8'h00;
    end
    else
    begin
      // status flags are never touched here
      file_wr_en_ff <= go && wr_op;
      if (go && wr_op)
        file_wr_data_ff <= rmw_data;
    end
  end

endmodule // bit_ops_branch_exec
`default_nettype wire

// ### hdl/bit_ops_defines.vh
// timing, field and encoding constants of the bit-op and branch executor
`ifndef BIT_OPS_DEFINES_VH
`define BIT_OPS_DEFINES_VH
`define OPC_GRP_LSB      12
`define OPC_GRP_BITS     2'h1
`define OPC_BITOP_LSB    10
`define OPC_BIT_LSB      7
`define OPC_F_LSB        0
`define BITOP_CLR        2'h0
`define BITOP_SET        2'h1
`define BITOP_TSC        2'h2
`define BITOP_TSS        2'h3
`define OPC_BRA_TOP      5'h19
`define OPC_BRW          14'h000b
`define INDF0_ADDR       7'h00
`define INDF1_ADDR       7'h01
`define PC_RST           15'h0000
`define SKIP_CYCLES      2'h1
`define IND_CYCLES       2'h1
`endif

// ### hdl/file_rmw_unit.v
// read-modify-write of one bit of a file register byte, with test result
`timescale 1ns/1ps
`default_nettype none
module file_rmw_unit
(
  input  wire [7:0] rd_data,
  input  wire [2:0] bit_sel,
  input  wire       set_val,
  output wire [7:0] wr_data,
  output wire       bit_val
);
  wire [7:0] mask;
  assign mask    = 8'h01 << bit_sel;
  // other bits pass through untouched
  assign wr_data = set_val ? (rd_data | mask) : (rd_data & ~mask);
  assign bit_val = |(rd_data & mask);
endmodule // file_rmw_unit
`default_nettype wire

// ### sim/bit_ops_branch_exec_props.sv
// assertions on the ports of the bit-op and branch executor
`timescale 1ns/1ps
`default_nettype none
module bit_ops_branch_exec_props (
  input wire logic clk, sys_rst, instr_valid, busy_ff, file_wr_en_ff, flush_ff, nop_cycle_ff,
  input wire logic [13:0] instr,
  input wire logic [7:0] wreg, file_rd_data, file_wr_data_ff,
  input wire logic [5:0] bank_sel,
  input wire logic [15:0] ptr0,
  input wire logic [14:0] pc_ff,
  input wire logic [12:0] data_addr_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire t = instr_valid && !busy_ff;
  // f 0 and 1 are indirect, so direct bit ops exclude them
  wire bo = t && instr[13:12] == 2'h1 && instr[6:1] != 6'h00;
  wire [1:0] op = instr[11:10];
  wire [7:0] m = 8'h01 << instr[9:7];
  wire tb = file_rd_data[instr[9:7]];
  property p_set; bo && op == 2'h1 |=> file_wr_en_ff && file_wr_data_ff == ($past(file_rd_data) | $past(m)); endproperty
  a_set: assert property (p_set) else $error("bad set");
  property p_clr; bo && op == 2'h0 |=> file_wr_en_ff && file_wr_data_ff == ($past(file_rd_data) & ~$past(m)); endproperty
  a_clr: assert property (p_clr) else $error("bad clear");
  property p_adr; bo |=> data_addr_ff == {$past(bank_sel), $past(instr[6:0])}; endproperty
  a_adr: assert property (p_adr) else $error("bad address");
  property p_tsc; bo && op == 2'h2 |=> flush_ff == !$past(tb); endproperty
  a_tsc: assert property (p_tsc) else $error("bad skip clear");
  property p_tss; bo && op == 2'h3 |=> flush_ff == $past(tb); endproperty
  a_tss: assert property (p_tss) else $error("bad skip set");
  property p_two; flush_ff |-> busy_ff ##1 nop_cycle_ff && !busy_ff; endproperty
  a_two: assert property (p_two) else $error("bad no-op cycle");
  property p_ind; t && instr[13:11] == 3'h2 && instr[6:0] == 7'h00 && ptr0[15] |=> !file_wr_en_ff ##1 file_wr_en_ff; endproperty
  a_ind: assert property (p_ind) else $error("bad indirect");
  property p_bra; t && instr[13:9] == 5'h19 |=> pc_ff == $past(pc_ff) + 15'h1 + {{6{$past(instr[8])}}, $past(instr[8:0])}; endproperty
  a_bra: assert property (p_bra) else $error("bad branch");
  property p_brw; t && instr == 14'h000b |=> pc_ff == $past(pc_ff) + 15'h1 + $past(wreg); endproperty
  a_brw: assert property (p_brw) else $error("bad w branch");
  c_flush: cover property (flush_ff);
  c_nop: cover property (nop_cycle_ff);
  c_set: cover property (bo && op == 2'h1);
endmodule // bit_ops_branch_exec_props
bind bit_ops_branch_exec bit_ops_branch_exec_props u_props (.clk(clk), .sys_rst(sys_rst),
  .instr_valid(instr_valid), .busy_ff(busy_ff), .file_wr_en_ff(file_wr_en_ff),
  .flush_ff(flush_ff), .nop_cycle_ff(nop_cycle_ff), .instr(instr), .wreg(wreg),
  .file_rd_data(file_rd_data), .file_wr_data_ff(file_wr_data_ff), .bank_sel(bank_sel),
  .ptr0(ptr0), .pc_ff(pc_ff), .data_addr_ff(data_addr_ff));
`default_nettype wire

// ### sim/bit_ops_branch_exec_tb.sv
// self-checking bench for the bit-op and branch executor
`timescale 1ns/1ps
`default_nettype none
module bit_ops_branch_exec_tb;
  logic clk, sys_rst, instr_valid, busy, wen, fl, nop;
  logic [13:0] instr;
  logic [7:0] wreg, file_rd_data, wd;
  logic [15:0] ptr0, ptr1, iptr;
  logic ind;
  logic [14:0] pc, pc_e;
  logic [12:0] adr;
  int mismatches, checks_done, cyc;
  bit_ops_branch_exec u_dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr(instr), .bank_sel(6'h2a), .wreg(wreg), .ptr0(ptr0), .ptr1(ptr1),
    .file_rd_data(file_rd_data), .busy_ff(busy), .pc_ff(pc), .data_addr_ff(adr),
    .file_wr_en_ff(wen), .file_wr_data_ff(wd), .ind_addr_ff(ind), .ind_ptr_ff(iptr),
    .flush_ff(fl), .nop_cycle_ff(nop));
  task automatic chk(input logic ok);
    checks_done++;
    if (ok !== 1'b1)
      $display("[ERR] %0t mismatch %0d", $time, ++mismatches);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one instruction taken, then look at the cycle after the take
  task automatic issue(input logic [13:0] i, input logic [7:0] d);
    @(posedge clk);
    instr <= i;
    file_rd_data <= d;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    pc_e = pc_e + 15'h1;
    #1;
  endtask
  task automatic t_bra(input logic [13:0] i, input logic [14:0] off);
    issue(i, 8'h00);
    pc_e = pc_e + off;
    chk(pc === pc_e && fl === 1'b1 && busy === 1'b1);
    @(posedge clk);
    #1;
    chk(nop === 1'b1 && busy === 1'b0);
  endtask
  task automatic t_skip(input logic [13:0] i, input logic [7:0] d, input logic s);
    issue(i, d);
    chk(fl === s && busy === s);
    if (s)
    begin
      @(posedge clk);
      #1;
      chk(nop === 1'b1);
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
    if (++cyc == 2000)
    begin
      mismatches++;
      close_out;
    end
  initial
  begin
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    instr = 14'h0000;
    wreg = 8'hff;
    ptr0 = 16'h8000;
    ptr1 = 16'h0123;
    file_rd_data = 8'h00;
    pc_e = 15'h0000;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    issue(14'h1505, 8'ha0);
    chk(wen === 1'b1 && wd === 8'ha4 && adr === {6'h2a, 7'h05} && busy === 1'b0);
    issue(14'h13ff, 8'hff);
    chk(wen === 1'b1 && wd === 8'h7f);
    t_bra(14'h3300, 15'h7f00);
    t_bra(14'h32ff, 15'h00ff);
    t_bra(14'h000b, 15'h00ff);
    t_skip(14'h1802, 8'h00, 1'b1);
    t_skip(14'h1802, 8'h01, 1'b0);
    t_skip(14'h1c02, 8'h01, 1'b1);
    t_skip(14'h1c02, 8'hfe, 1'b0);
    issue(14'h1400, 8'h00);
    chk(wen === 1'b0 && busy === 1'b1);
    @(posedge clk);
    #1;
    chk(wen === 1'b1 && wd === 8'h01 && ind === 1'b1 && iptr === 16'h8000);
    issue(14'h1401, 8'h10);
    chk(wen === 1'b1 && wd === 8'h11 && busy === 1'b0 && ind === 1'b1);
    chk(iptr === 16'h0123 && pc === pc_e);
    close_out;
  end
endmodule // bit_ops_branch_exec_tb
`default_nettype wire
